// ==== hdl/smt_top.sv ====
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// What this block does
// - A destination look-up consults both the static table and the dynamic result.
// - A source look-up uses only the dynamic result and never the static table.
// - When both tables match a destination, the static result is forwarded.
// - Only the management master reaches the table entries; look-ups only read them.
// - Entries never age or vanish by themselves; only a management write changes them.
// - Read-back holds filter group id at 63-57, zero at 55 and MAC at 47-0.
// - With the match-enable bit set an entry matches on group id plus MAC, else MAC only.
// - Only entries whose valid bit is set yield a look-up result.
// - The five-bit mask is one bit per port, and all ones excludes the ingress port.
// - Read-back and write use different bit layouts for the entry data.
// - The table holds 32 entries, each chosen by index through indirect access.
module smt_top #(
	parameter int ENTRIES = smt_pkg::ENTRIES
) (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic LK_REQ,
	input wire logic LK_SA,
	input wire logic [smt_pkg::MAC_W-1:0] LK_MAC,
	input wire logic [smt_pkg::GRP_ID_W-1:0] LK_GRP,
	input wire logic [smt_pkg::PORTS-1:0] LK_IN_PORT,
	input wire logic DYN_HIT,
	input wire logic [smt_pkg::PORTS-1:0] DYN_PORTS,
	output logic FWD_VALID,
	output logic FWD_HIT,
	output logic FWD_STATIC,
	output logic FWD_OVERRIDE,
	output logic [smt_pkg::PORTS-1:0] FWD_PORTS
);
	localparam int MW = smt_pkg::MAC_W;
	localparam int FW = smt_pkg::GRP_ID_W;
	localparam int PW = smt_pkg::PORTS;
	localparam int IW = smt_pkg::IDX_W;

	if (ENTRIES < 1 || ENTRIES > (1 << IW)) begin : g_chk
		$error("ENTRIES must lie between 1 and 32");
	end

	// Bus slave
	smt_pkg::smt_bus_e bus_q, bus_d;
	logic [31:0] dat_q, dat_d;
	logic req, wr;

	// Indirect access registers
	logic [IW-1:0] idx_q, idx_d;
	logic rdsel_q, rdsel_d;
	logic [63:0] data_q, data_d;
	logic trig, trig_rd, trig_wr, idx_ok;

	// Table storage
	logic [ENTRIES-1:0][MW-1:0] mac_q, mac_d;
	logic [ENTRIES-1:0][FW-1:0] grp_q, grp_d;
	logic [ENTRIES-1:0] use_q, use_d;
	logic [ENTRIES-1:0] ovr_q, ovr_d;
	logic [ENTRIES-1:0] vld_q, vld_d;
	logic [ENTRIES-1:0][PW-1:0] ports_q, ports_d;

	// Look-up result
	logic st_hit;
	logic [IW-1:0] st_idx;
	logic [PW-1:0] hit_ports;
	logic fv_q, fv_d, fh_q, fh_d, fs_q, fs_d, fo_q, fo_d;
	logic [PW-1:0] fp_q, fp_d;
	logic [IW-1:0] last_idx_q, last_idx_d;
	logic last_hit_q, last_hit_d;

	assign req = CYC_I & STB_I;
	// Write lands on the edge where the master sees ack
	assign wr = req & WE_I & (bus_q == smt_pkg::BUS_ACK);
	assign idx_ok = 32'(idx_q) < ENTRIES;

	always_comb begin
		bus_d = smt_pkg::BUS_IDLE;
		dat_d = dat_q;
		if (req && bus_q == smt_pkg::BUS_IDLE) begin
			bus_d = smt_pkg::BUS_ACK;
			dat_d = smt_pkg::RST_WORD;
			if (ADR_I == smt_pkg::ADR_CTRL) begin
				dat_d[smt_pkg::CTRL_IDX_LSB +: IW] = idx_q;
				dat_d[smt_pkg::CTRL_RDSEL_BIT] = rdsel_q;
			end else if (ADR_I == smt_pkg::ADR_DATA_HI) begin
				dat_d = data_q[63:32];
			end else if (ADR_I == smt_pkg::ADR_DATA_LO) begin
				dat_d = data_q[31:0];
			end else if (ADR_I == smt_pkg::ADR_STATUS) begin
				dat_d[smt_pkg::STAT_IDX_LSB +: IW] = last_idx_q;
				dat_d[smt_pkg::STAT_HIT_BIT] = last_hit_q;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			bus_q <= smt_pkg::BUS_IDLE;
			dat_q <= smt_pkg::RST_WORD;
		end else begin
			bus_q <= bus_d;
			dat_q <= dat_d;
		end
	end

	assign ACK_O = (bus_q == smt_pkg::BUS_ACK);
	assign DAT_O = dat_q;

	// Indirect access: index, select, data window, trigger
	always_comb begin
		logic [31:0] cw;
		cw = smt_pkg::RST_WORD;
		idx_d = idx_q;
		rdsel_d = rdsel_q;
		data_d = data_q;
		trig = 1'b0;
		if (wr) begin
			if (ADR_I == smt_pkg::ADR_CTRL) begin
				cw[smt_pkg::CTRL_IDX_LSB +: IW] = idx_q;
				cw[smt_pkg::CTRL_RDSEL_BIT] = rdsel_q;
				cw = smt_pkg::sel_merge(cw, DAT_I, SEL_I);
				idx_d = cw[smt_pkg::CTRL_IDX_LSB +: IW];
				rdsel_d = cw[smt_pkg::CTRL_RDSEL_BIT];
			end else if (ADR_I == smt_pkg::ADR_TRIG) begin
				trig = SEL_I[0] & DAT_I[smt_pkg::TRIG_GO_BIT];
			end else if (ADR_I == smt_pkg::ADR_DATA_HI) begin
				data_d[63:32] = smt_pkg::sel_merge(data_q[63:32], DAT_I, SEL_I);
			end else if (ADR_I == smt_pkg::ADR_DATA_LO) begin
				data_d[31:0] = smt_pkg::sel_merge(data_q[31:0], DAT_I, SEL_I);
			end
		end
		if (trig && rdsel_q) begin
			data_d = '0;
			if (idx_ok) begin
				data_d = smt_pkg::pack_rd(grp_q[idx_q], use_q[idx_q], ovr_q[idx_q],
					vld_q[idx_q], ports_q[idx_q], mac_q[idx_q]);
			end
		end
	end

	assign trig_rd = trig & rdsel_q;
	assign trig_wr = trig & ~rdsel_q;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			idx_q <= '0;
			rdsel_q <= 1'b0;
			data_q <= '0;
		end else begin
			idx_q <= idx_d;
			rdsel_q <= rdsel_d;
			data_q <= data_d;
		end
	end

	// Entries change only on a management write trigger; nothing ages them
	always_comb begin
		mac_d = mac_q;
		grp_d = grp_q;
		use_d = use_q;
		ovr_d = ovr_q;
		vld_d = vld_q;
		ports_d = ports_q;
		if (trig_wr && idx_ok) begin
			mac_d[idx_q] = data_q[smt_pkg::MAC_LSB +: MW];
			grp_d[idx_q] = data_q[smt_pkg::WR_GRP_LSB +: FW];
			use_d[idx_q] = data_q[smt_pkg::WR_USE_BIT];
			ovr_d[idx_q] = data_q[smt_pkg::OVR_BIT];
			vld_d[idx_q] = data_q[smt_pkg::VLD_BIT];
			ports_d[idx_q] = data_q[smt_pkg::PORTS_LSB +: PW];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			mac_q <= '0;
			grp_q <= '0;
			use_q <= '0;
			ovr_q <= '0;
			vld_q <= '0;
			ports_q <= '0;
		end else begin
			mac_q <= mac_d;
			grp_q <= grp_d;
			use_q <= use_d;
			ovr_q <= ovr_d;
			vld_q <= vld_d;
			ports_q <= ports_d;
		end
	end

	smt_match #(
		.N(ENTRIES)
	) smt_match_inst (
		.mac(mac_q),
		.grp_id(grp_q),
		.grp_en(use_q),
		.vld(vld_q),
		.key_mac(LK_MAC),
		.key_grp(LK_GRP),
		.hit(st_hit),
		.idx(st_idx)
	);

	assign hit_ports = ports_q[st_idx];

	// Look-up answer one cycle after the request
	always_comb begin
		fv_d = LK_REQ;
		fh_d = DYN_HIT;
		fs_d = 1'b0;
		fo_d = 1'b0;
		fp_d = DYN_PORTS;
		last_idx_d = last_idx_q;
		last_hit_d = last_hit_q;
		if (!LK_REQ) begin
			fh_d = 1'b0;
			fp_d = '0;
		end else if (!LK_SA) begin
			last_hit_d = st_hit;
			if (st_hit) begin
				last_idx_d = st_idx;
				fh_d = 1'b1;
				fs_d = 1'b1;
				fo_d = ovr_q[st_idx];
				fp_d = hit_ports;
				if (&hit_ports) begin
					fp_d = hit_ports & ~LK_IN_PORT;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			fv_q <= 1'b0;
			fh_q <= 1'b0;
			fs_q <= 1'b0;
			fo_q <= 1'b0;
			fp_q <= '0;
			last_idx_q <= '0;
			last_hit_q <= 1'b0;
		end else begin
			fv_q <= fv_d;
			fh_q <= fh_d;
			fs_q <= fs_d;
			fo_q <= fo_d;
			fp_q <= fp_d;
			last_idx_q <= last_idx_d;
			last_hit_q <= last_hit_d;
		end
	end

	assign FWD_VALID = fv_q;
	assign FWD_HIT = fh_q;
	assign FWD_STATIC = fs_q;
	assign FWD_OVERRIDE = fo_q;
	assign FWD_PORTS = fp_q;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	property p_da_answer;
		LK_REQ && !LK_SA |=> FWD_VALID && (FWD_HIT == $past(st_hit | DYN_HIT));
	endproperty
	a_da_answer: assert property (p_da_answer) else $error("DA look-up answer wrong");

	property p_sa_dyn_only;
		LK_REQ && LK_SA |=> !FWD_STATIC && FWD_PORTS == $past(DYN_PORTS)
			&& FWD_HIT == $past(DYN_HIT);
	endproperty
	a_sa_dyn_only: assert property (p_sa_dyn_only) else $error("SA used static table");

	property p_static_wins;
		LK_REQ && !LK_SA && st_hit && DYN_HIT |=> FWD_STATIC && FWD_HIT;
	endproperty
	a_static_wins: assert property (p_static_wins) else $error("Static did not win");

	property p_no_aging;
		!trig_wr |=> $stable(vld_q) && $stable(mac_q);
	endproperty
	a_no_aging: assert property (p_no_aging) else $error("Entry changed without write");

	property p_rd_layout;
		trig_rd && idx_ok |=> !data_q[smt_pkg::RD_RSV_BIT]
			&& data_q[smt_pkg::VLD_BIT] == $past(vld_q[idx_q]);
	endproperty
	a_rd_layout: assert property (p_rd_layout) else $error("Read-back layout wrong");

	property p_override;
		FWD_OVERRIDE |-> FWD_STATIC && FWD_VALID;
	endproperty
	a_override: assert property (p_override) else $error("Override without static hit");

	property p_bcast_excl;
		LK_REQ && !LK_SA && st_hit && (&hit_ports) |=>
			(FWD_PORTS & $past(LK_IN_PORT)) == '0 && FWD_PORTS != '0 || $past(&LK_IN_PORT);
	endproperty
	a_bcast_excl: assert property (p_bcast_excl) else $error("Broadcast hit ingress");

	property p_fall_through;
		LK_REQ && !LK_SA && !st_hit |=> !FWD_STATIC && FWD_PORTS == $past(DYN_PORTS);
	endproperty
	a_fall_through: assert property (p_fall_through) else $error("Miss not dynamic");

	property p_bus_ack;
		req && !ACK_O |=> ACK_O ##1 !ACK_O;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("Bus ack timing wrong");

	property p_idle_zero;
		!FWD_VALID |-> !FWD_HIT && !FWD_STATIC && !FWD_OVERRIDE && FWD_PORTS == '0;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("Result without request");

	c_static_hit: cover property (LK_REQ && !LK_SA && st_hit ##1 FWD_STATIC);
	c_both_hit: cover property (LK_REQ && !LK_SA && st_hit && DYN_HIT);
	c_wr_entry: cover property (trig_wr && idx_ok);
	c_rd_entry: cover property (trig_rd && idx_ok);
endmodule

// ==== hdl/smt_pkg.sv ====
package smt_pkg;
	localparam int ENTRIES = 32;
	localparam int IDX_W = 5;
	localparam int MAC_W = 48;
	localparam int GRP_ID_W = 7;
	localparam int PORTS = 5;

	// Wishbone byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_TRIG = 8'h04;
	localparam logic [7:0] ADR_DATA_HI = 8'h08;
	localparam logic [7:0] ADR_DATA_LO = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;

	// Control and trigger register fields
	localparam int CTRL_IDX_LSB = 0;
	localparam int CTRL_RDSEL_BIT = 8;
	localparam int TRIG_GO_BIT = 0;
	// Status register fields
	localparam int STAT_IDX_LSB = 0;
	localparam int STAT_HIT_BIT = 8;

	// Entry layout, shared positions
	localparam int MAC_LSB = 0;
	localparam int PORTS_LSB = 48;
	localparam int VLD_BIT = 53;
	localparam int OVR_BIT = 54;
	// Read-back layout
	localparam int RD_RSV_BIT = 55;
	localparam int RD_USE_BIT = 56;
	localparam int RD_GRP_LSB = 57;
	// Write layout
	localparam int WR_USE_BIT = 55;
	localparam int WR_GRP_LSB = 56;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} smt_bus_e;

	function automatic logic [31:0] sel_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Reserved bit 55 reads as zero
	function automatic logic [63:0] pack_rd(input logic [GRP_ID_W-1:0] grp_id,
		input logic use_f, input logic ovr, input logic vld,
		input logic [PORTS-1:0] ports, input logic [MAC_W-1:0] mac);
		return {grp_id, use_f, 1'b0, ovr, vld, ports, mac};
	endfunction
endpackage

// ==== hdl/smt_match.sv ====
`timescale 1ns/1ps
module smt_match #(
	parameter int N = smt_pkg::ENTRIES
) (
	input wire logic [N-1:0][smt_pkg::MAC_W-1:0] mac,
	input wire logic [N-1:0][smt_pkg::GRP_ID_W-1:0] grp_id,
	input wire logic [N-1:0] grp_en,
	input wire logic [N-1:0] vld,
	input wire logic [smt_pkg::MAC_W-1:0] key_mac,
	input wire logic [smt_pkg::GRP_ID_W-1:0] key_grp,
	output logic hit,
	output logic [smt_pkg::IDX_W-1:0] idx
);
	// Lowest index wins when several entries match
	always_comb begin
		hit = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (vld[i] && mac[i] == key_mac && (!grp_en[i] || grp_id[i] == key_grp)) begin
				hit = 1'b1;
				idx = smt_pkg::IDX_W'(i);
			end
		end
	end
endmodule

// ==== tb/smt_mgmt_model.sv ====
`timescale 1ns/1ps
module smt_mgmt_model (
	input wire logic clk,
	input wire logic ack,
	input wire logic [31:0] dat_in,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat_out,
	output logic hung
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat_out = 32'h0000_0000;
		hung = 1'b0;
	end

	// Request held until ack is sampled, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat_out <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		hung <= (ack !== 1'b1);
		q = dat_in;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr_entry(input logic [4:0] idx, input logic [6:0] grp,
		input logic use_f, input logic ovr, input logic vld, input logic [4:0] ports,
		input logic [47:0] mac);
		logic [31:0] q;
		bus(1'b1, smt_pkg::ADR_DATA_HI, {1'b0, grp, use_f, ovr, vld, ports, mac[47:32]}, q);
		bus(1'b1, smt_pkg::ADR_DATA_LO, mac[31:0], q);
		bus(1'b1, smt_pkg::ADR_CTRL, {27'h000_0000, idx}, q);
		bus(1'b1, smt_pkg::ADR_TRIG, 32'h0000_0001, q);
	endtask

	task automatic rd_entry(input logic [4:0] idx, output logic [63:0] v);
		logic [31:0] q;
		bus(1'b1, smt_pkg::ADR_CTRL, {23'h00_0000, 1'b1, 3'h0, idx}, q);
		bus(1'b1, smt_pkg::ADR_TRIG, 32'h0000_0001, q);
		bus(1'b0, smt_pkg::ADR_DATA_HI, 32'h0000_0000, q);
		v[63:32] = q;
		bus(1'b0, smt_pkg::ADR_DATA_LO, 32'h0000_0000, q);
		v[31:0] = q;
	endtask
endmodule

// ==== tb/static_mac_address_table_tb.sv ====
`timescale 1ns/1ps
module static_mac_address_table_tb;
	localparam logic [47:0] MAC_A = 48'h0011_2233_4455;
	localparam logic [47:0] MAC_B = 48'h0011_2233_4466;
	localparam logic [47:0] MAC_C = 48'h00AA_BBCC_DDEE;
	logic CLK_SYS, RST_B, CYC_I, STB_I, WE_I, ACK_O, hung;
	logic [7:0] ADR_I;
	logic [3:0] SEL_I;
	logic [31:0] DAT_I, DAT_O, q;
	logic LK_REQ, LK_SA, DYN_HIT, FWD_VALID, FWD_HIT, FWD_STATIC, FWD_OVERRIDE;
	logic [47:0] LK_MAC;
	logic [6:0] LK_GRP;
	logic [4:0] LK_IN_PORT, DYN_PORTS, FWD_PORTS;
	logic [63:0] v;
	int err_count = 0;
	int n_checks = 0;

	smt_top smt_top_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CYC_I(CYC_I), .STB_I(STB_I),
		.WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
		.ACK_O(ACK_O), .LK_REQ(LK_REQ), .LK_SA(LK_SA), .LK_MAC(LK_MAC), .LK_GRP(LK_GRP),
		.LK_IN_PORT(LK_IN_PORT), .DYN_HIT(DYN_HIT), .DYN_PORTS(DYN_PORTS),
		.FWD_VALID(FWD_VALID), .FWD_HIT(FWD_HIT), .FWD_STATIC(FWD_STATIC),
		.FWD_OVERRIDE(FWD_OVERRIDE), .FWD_PORTS(FWD_PORTS));
	smt_mgmt_model smt_mgmt_model_inst (.clk(CLK_SYS), .ack(ACK_O), .dat_in(DAT_O),
		.cyc(CYC_I), .stb(STB_I), .we(WE_I), .adr(ADR_I), .sel(SEL_I), .dat_out(DAT_I),
		.hung(hung));

	initial begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end

	task automatic complete_run();
		$display("Checks: %0d, mismatches: %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask

	// Expected vector is {valid, hit, static, override, ports}
	task automatic lk(input logic sa, input logic [47:0] mac, input logic [6:0] grp,
		input logic [4:0] inp, input logic dh, input logic [4:0] dp, input logic [8:0] exp);
		@(posedge CLK_SYS);
		LK_REQ <= 1'b1;
		LK_SA <= sa;
		LK_MAC <= mac;
		LK_GRP <= grp;
		LK_IN_PORT <= inp;
		DYN_HIT <= dh;
		DYN_PORTS <= dp;
		@(posedge CLK_SYS);
		LK_REQ <= 1'b0;
		#1;
		chk({55'h0, FWD_VALID, FWD_HIT, FWD_STATIC, FWD_OVERRIDE, FWD_PORTS},
			{55'h0, exp}, "lookup result");
		@(posedge CLK_SYS);
		#1;
		chk({63'h0, FWD_VALID}, 64'h0000_0000_0000_0000, "valid not single pulse");
	endtask

	always @(posedge CLK_SYS) begin
		if (hung === 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: bus timeout", $time);
			complete_run();
		end
	end

	initial begin
		RST_B = 1'b0;
		LK_REQ = 1'b0;
		LK_SA = 1'b0;
		LK_MAC = 48'h0000_0000_0000;
		LK_GRP = 7'h00;
		LK_IN_PORT = 5'h00;
		DYN_HIT = 1'b0;
		DYN_PORTS = 5'h00;
		repeat (2) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		smt_mgmt_model_inst.rd_entry(5'd31, v);
		chk(v, 64'h0000_0000_0000_0000, "entry not clear after reset");
		smt_mgmt_model_inst.bus(1'b0, 8'h20, 32'h0000_0000, q);
		chk({32'h0000_0000, q}, 64'h0000_0000_0000_0000, "unmapped read");
		smt_mgmt_model_inst.wr_entry(5'd3, 7'h55, 1'b1, 1'b1, 1'b1, 5'h1F, MAC_A);
		smt_mgmt_model_inst.rd_entry(5'd3, v);
		chk(v, {7'h55, 1'b1, 1'b0, 1'b1, 1'b1, 5'h1F, MAC_A}, "read layout");
		smt_mgmt_model_inst.bus(1'b0, smt_pkg::ADR_CTRL, 32'h0000_0000, q);
		chk({32'h0000_0000, q}, 64'h0000_0000_0000_0103, "control read-back");
		lk(1'b0, MAC_A, 7'h55, 5'h04, 1'b1, 5'h02, {4'hF, 5'h1B});
		lk(1'b0, MAC_A, 7'h11, 5'h04, 1'b1, 5'h02, {4'hC, 5'h02});
		lk(1'b1, MAC_A, 7'h55, 5'h04, 1'b1, 5'h09, {4'hC, 5'h09});
		smt_mgmt_model_inst.wr_entry(5'd31, 7'h00, 1'b0, 1'b0, 1'b1, 5'h06, MAC_B);
		lk(1'b0, MAC_B, 7'h33, 5'h02, 1'b0, 5'h00, {4'hE, 5'h06});
		smt_mgmt_model_inst.bus(1'b0, smt_pkg::ADR_STATUS, 32'h0000_0000, q);
		chk({32'h0000_0000, q}, 64'h0000_0000_0000_011F, "status after hit");
		smt_mgmt_model_inst.wr_entry(5'd6, 7'h00, 1'b0, 1'b1, 1'b0, 5'h1F, MAC_C);
		lk(1'b0, MAC_C, 7'h00, 5'h01, 1'b0, 5'h00, {4'h8, 5'h00});
		smt_mgmt_model_inst.bus(1'b0, smt_pkg::ADR_STATUS, 32'h0000_0000, q);
		chk({32'h0000_0000, q}, 64'h0000_0000_0000_001F, "status after miss");
		// Long idle: entries must not age
		repeat (300) @(posedge CLK_SYS);
		lk(1'b0, MAC_A, 7'h55, 5'h10, 1'b0, 5'h00, {4'hF, 5'h0F});
		smt_mgmt_model_inst.wr_entry(5'd3, 7'h55, 1'b1, 1'b1, 1'b0, 5'h1F, MAC_A);
		lk(1'b0, MAC_A, 7'h55, 5'h10, 1'b1, 5'h08, {4'hC, 5'h08});
		complete_run();
	end
endmodule
